// *** logic/phcu_pkg.sv ***
package phcu_pkg;

	localparam int unsigned PHCU_ADDR_W = 8;
	localparam int unsigned PHCU_DATA_W = 32;

	// Register offsets, byte addresses of aligned words.
	localparam logic [7:0] PHCU_OFF_MEM_WINDOW_BASE = 8'h14;
	localparam logic [7:0] PHCU_OFF_SUBSYSTEM_IDENTITY = 8'h2c;
	localparam logic [7:0] PHCU_OFF_EXPANSION_ROM_BASE = 8'h30;
	localparam logic [7:0] PHCU_OFF_CAPABILITY_LIST_START = 8'h34;
	localparam logic [7:0] PHCU_OFF_INTERRUPT_AND_BUS_HINTS = 8'h3c;
	localparam logic [7:0] PHCU_OFF_DRIVER_SCRATCH = 8'h40;

	// Field positions.
	localparam int unsigned PHCU_MEM_BASE_LSB = 7;
	localparam int unsigned PHCU_MEM_BASE_W = 25;
	localparam int unsigned PHCU_ROM_BASE_LSB = 17;
	localparam int unsigned PHCU_ROM_BASE_W = 15;
	localparam int unsigned PHCU_ROM_EN_BIT = 0;
	localparam int unsigned PHCU_SCRATCH_LSB = 8;
	localparam int unsigned PHCU_BYTE_W = 8;
	localparam int unsigned PHCU_HALF_W = 16;

	// Reset and fixed values.
	localparam logic [24:0] PHCU_MEM_BASE_RST = 25'h0000000;
	localparam logic [14:0] PHCU_ROM_BASE_RST = 15'h0000;
	localparam logic PHCU_ROM_EN_RST = 1'h0;
	localparam logic [7:0] PHCU_INT_LINE_RST = 8'h00;
	localparam logic [7:0] PHCU_SCRATCH_RST = 8'h00;
	localparam logic [7:0] PHCU_CAP_START = 8'hc0;
	localparam logic [7:0] PHCU_INT_PIN = 8'h01;
	localparam logic [31:0] PHCU_ZERO_WORD = 32'h00000000;
	localparam logic PHCU_SPACE_TYPE_FLAG = 1'h0;

	// Bus hint unit, used by the host to scale max_latency and min_grant.
	localparam int unsigned PHCU_HINT_UNIT_NS = 250;
	localparam int unsigned PHCU_CLK_PERIOD_NS = 10;
	localparam int unsigned PHCU_HINT_UNIT_CYC =
		PHCU_HINT_UNIT_NS / PHCU_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PHCU_LD_WAIT = 2'b00,
		PHCU_LD_DONE = 2'b01
	} phcu_load_state_type;

endpackage : phcu_pkg

// *** logic/phcu_ident_loader.sv ***
`timescale 1ns/1ps
module phcu_ident_loader import phcu_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_load_valid,
	input wire logic [31:0] i_load_ident,
	input wire logic [15:0] i_load_hints,
	output logic [31:0] o_ident,
	output logic [15:0] o_hints,
	output logic o_loaded
);

	typedef struct packed {
		phcu_load_state_type state;
		logic [31:0] ident;
		logic [15:0] hints;
	} phcu_loader_type;

	phcu_loader_type st_reg;
	phcu_loader_type st_next;

	// Only the first image after a hardware reset is taken; later strobes
	// are ignored so the read-only fields cannot be changed at run time.
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			PHCU_LD_WAIT: begin
				if (i_load_valid) begin
					st_next.ident = i_load_ident;
					st_next.hints = i_load_hints;
					st_next.state = PHCU_LD_DONE;
				end
			end
			default: st_next.state = PHCU_LD_DONE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '{PHCU_LD_WAIT, PHCU_ZERO_WORD, 16'h0000};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_ident = st_reg.ident;
	assign o_hints = st_reg.hints;
	assign o_loaded = (st_reg.state == PHCU_LD_DONE);

endmodule : phcu_ident_loader

// *** logic/phcu_space_decoder.sv ***
`timescale 1ns/1ps
module phcu_space_decoder import phcu_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic [31:0] i_probe_addr,
	input wire logic i_mem_space_en,
	input wire logic [24:0] i_mem_base,
	input wire logic [14:0] i_rom_base,
	input wire logic i_rom_en,
	output logic o_mem_hit,
	output logic o_rom_hit
);

	typedef struct packed {
		logic mem_hit;
		logic rom_hit;
	} phcu_decode_type;

	phcu_decode_type st_reg;
	phcu_decode_type st_next;

	always_comb begin
		st_next = st_reg;
		st_next.mem_hit = i_mem_space_en &&
			(i_probe_addr[31:PHCU_MEM_BASE_LSB] == i_mem_base);
		// Both enables are needed, so a stale base cannot claim cycles.
		st_next.rom_hit = i_mem_space_en && i_rom_en &&
			(i_probe_addr[31:PHCU_ROM_BASE_LSB] == i_rom_base);
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '{1'b0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_mem_hit = st_reg.mem_hit;
	assign o_rom_hit = st_reg.rom_hit;

endmodule : phcu_space_decoder

// *** logic/phcu_config_upper.sv ***
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module phcu_config_upper import phcu_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic i_soft_reset,
	input wire logic i_mem_space_en,
	input wire logic i_eeprom_valid,
	input wire logic [31:0] i_eeprom_ident,
	input wire logic [15:0] i_eeprom_hints,
	input wire logic [31:0] i_probe_addr,
	output logic [31:0] o_reg_rdata,
	output logic o_mem_hit,
	output logic o_rom_hit,
	output logic o_ident_loaded,
	output logic [7:0] o_interrupt_line
);

	typedef struct packed {
		logic [24:0] mem_window_base;
		logic [14:0] expansion_rom_base;
		logic rom_decode_enable;
		logic [7:0] interrupt_line;
		logic [7:0] driver_scratch;
		logic [31:0] rdata;
		logic ident_loaded;
	} phcu_regs_type;

	phcu_regs_type st_reg;
	phcu_regs_type st_next;

	logic [31:0] ident_word;
	logic [15:0] hint_word;
	logic loaded;

	// Takes the image once after hardware reset; software reset leaves it.
	phcu_ident_loader u_loader (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_load_valid(i_eeprom_valid),
		.i_load_ident(i_eeprom_ident),
		.i_load_hints(i_eeprom_hints),
		.o_ident(ident_word),
		.o_hints(hint_word),
		.o_loaded(loaded)
	);

	phcu_space_decoder u_decoder (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_probe_addr(i_probe_addr),
		.i_mem_space_en(i_mem_space_en),
		.i_mem_base(st_reg.mem_window_base),
		.i_rom_base(st_reg.expansion_rom_base),
		.i_rom_en(st_reg.rom_decode_enable),
		.o_mem_hit(o_mem_hit),
		.o_rom_hit(o_rom_hit)
	);

	function automatic logic [31:0] phcu_read_word(
		input logic [7:0] addr,
		input phcu_regs_type r,
		input logic [31:0] ident,
		input logic [15:0] hints
	);
		logic [31:0] w;
		w = PHCU_ZERO_WORD;
		if (addr == PHCU_OFF_MEM_WINDOW_BASE) begin
			w[31:PHCU_MEM_BASE_LSB] = r.mem_window_base;
			w[0] = PHCU_SPACE_TYPE_FLAG;
		end else if (addr == PHCU_OFF_SUBSYSTEM_IDENTITY) begin
			w = ident;
		end else if (addr == PHCU_OFF_EXPANSION_ROM_BASE) begin
			w[31:PHCU_ROM_BASE_LSB] = r.expansion_rom_base;
			w[PHCU_ROM_EN_BIT] = r.rom_decode_enable;
		end else if (addr == PHCU_OFF_CAPABILITY_LIST_START) begin
			w[PHCU_BYTE_W-1:0] = PHCU_CAP_START;
		end else if (addr == PHCU_OFF_INTERRUPT_AND_BUS_HINTS) begin
			w[31:PHCU_HALF_W] = hints;
			w[PHCU_HALF_W-1:PHCU_BYTE_W] = PHCU_INT_PIN;
			w[PHCU_BYTE_W-1:0] = r.interrupt_line;
		end else if (addr == PHCU_OFF_DRIVER_SCRATCH) begin
			w[PHCU_HALF_W-1:PHCU_SCRATCH_LSB] = r.driver_scratch;
		end else begin
			w = PHCU_ZERO_WORD;
		end
		return w;
	endfunction : phcu_read_word

	always_comb begin
		st_next = st_reg;
		st_next.ident_loaded = loaded;
		// Software reset restores every writable field but the scratch byte.
		if (i_soft_reset) begin
			st_next.mem_window_base = PHCU_MEM_BASE_RST;
			st_next.expansion_rom_base = PHCU_ROM_BASE_RST;
			st_next.rom_decode_enable = PHCU_ROM_EN_RST;
			st_next.interrupt_line = PHCU_INT_LINE_RST;
		end else if (i_reg_wr) begin
			// Only named fields are stored; reserved bits are dropped.
			if (i_reg_addr == PHCU_OFF_MEM_WINDOW_BASE) begin
				st_next.mem_window_base =
					i_reg_wdata[31:PHCU_MEM_BASE_LSB];
			end else if (i_reg_addr == PHCU_OFF_EXPANSION_ROM_BASE) begin
				st_next.expansion_rom_base =
					i_reg_wdata[31:PHCU_ROM_BASE_LSB];
				st_next.rom_decode_enable =
					i_reg_wdata[PHCU_ROM_EN_BIT];
			end else if (i_reg_addr == PHCU_OFF_INTERRUPT_AND_BUS_HINTS) begin
				st_next.interrupt_line =
					i_reg_wdata[PHCU_BYTE_W-1:0];
			end
		end
		if (i_reg_wr && (i_reg_addr == PHCU_OFF_DRIVER_SCRATCH)) begin
			st_next.driver_scratch =
				i_reg_wdata[PHCU_HALF_W-1:PHCU_SCRATCH_LSB];
		end
		// Read data stand only in the cycle after the read strobe.
		if (i_reg_rd) begin
			st_next.rdata = phcu_read_word(i_reg_addr, st_reg,
				ident_word, hint_word);
		end else begin
			st_next.rdata = PHCU_ZERO_WORD;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '{PHCU_MEM_BASE_RST, PHCU_ROM_BASE_RST, PHCU_ROM_EN_RST,
				PHCU_INT_LINE_RST, PHCU_SCRATCH_RST, PHCU_ZERO_WORD,
				1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_reg_rdata = st_reg.rdata;
	assign o_ident_loaded = st_reg.ident_loaded;
	assign o_interrupt_line = st_reg.interrupt_line;

endmodule : phcu_config_upper

// *** tb/phcu_host_model.sv ***
`timescale 1ns/1ps
// Host side of the register bus; the slave never stalls, so no wait.
module phcu_host_model (
	input wire logic i_sys_clk,
	input wire logic [31:0] i_rdata,
	output logic [7:0] o_addr = 8'h00,
	output logic [31:0] o_wdata = 32'h0,
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		// Released data is scrambled so stale values are not read as good.
		o_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask : rd
endmodule : phcu_host_model

// *** tb/phcu_config_upper_asserts.sv ***
`timescale 1ns/1ps
module phcu_config_upper_asserts (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic i_mem_space_en,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_mem_hit,
	input wire logic o_rom_hit,
	input wire logic [7:0] o_interrupt_line
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	property rd_bits(logic [7:0] a, logic [31:0] m, logic [31:0] v);
		$past(i_reg_rd) && $past(i_reg_addr) == a |-> (o_reg_rdata & m) == v;
	endproperty
	rdata_idle_a: assert property (
		!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	mem_low_a: assert property (
		rd_bits(8'h14, 32'h7f, 32'h0))
		else $error("memory base low bits not zero");
	rom_low_a: assert property (
		rd_bits(8'h30, 32'h1fffe, 32'h0))
		else $error("ROM base low bits not zero");
	cap_fixed_a: assert property (
		rd_bits(8'h34, 32'hffffffff, 32'hc0))
		else $error("capability start wrong");
	int_pin_a: assert property (
		rd_bits(8'h3c, 32'hff00, 32'h100))
		else $error("interrupt pin wrong");
	scratch_rsv_a: assert property (
		rd_bits(8'h40, 32'hffff00ff, 32'h0))
		else $error("scratch reserved bits not zero");
	int_line_a: assert property (
		$past(i_reg_rd) && $past(i_reg_addr) == 8'h3c
		|-> o_reg_rdata[7:0] == $past(o_interrupt_line))
		else $error("interrupt line read differs from output");
	rom_gate_a: assert property (
		o_rom_hit |-> $past(i_mem_space_en))
		else $error("ROM hit without memory space enable");
	cover property (o_mem_hit);
	cover property (o_rom_hit);
	cover property ($past(i_reg_rd) && o_reg_rdata != 0);
endmodule : phcu_config_upper_asserts
bind phcu_config_upper phcu_config_upper_asserts u_phcu_config_upper_asserts (
	.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
	.i_reg_rd(i_reg_rd), .i_mem_space_en(i_mem_space_en),
	.o_reg_rdata(o_reg_rdata), .o_mem_hit(o_mem_hit), .o_rom_hit(o_rom_hit),
	.o_interrupt_line(o_interrupt_line));

// *** tb/tb_phcu_config_upper.sv ***
`timescale 1ns/1ps
module tb_phcu_config_upper;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr, il;
	logic [31:0] wdata, rdata;
	logic [31:0] eid = 32'h5a5a3c3c;
	logic [31:0] probe = 32'h0;
	logic [15:0] eh = 16'h1234;
	logic wr, rd, mh, rh, ld;
	logic sr = 1'b0;
	logic men = 1'b0;
	logic ev = 1'b0;
	int n_mismatch = 0;
	int num_checks = 0;
	always #5 clk = ~clk;
	phcu_config_upper u_phcu_config_upper (.i_sys_clk(clk), .i_nrst(nrst),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_soft_reset(sr), .i_mem_space_en(men), .i_eeprom_valid(ev),
		.i_eeprom_ident(eid), .i_eeprom_hints(eh), .i_probe_addr(probe),
		.o_reg_rdata(rdata), .o_mem_hit(mh), .o_rom_hit(rh),
		.o_ident_loaded(ld), .o_interrupt_line(il));
	phcu_host_model u_phcu_host_model (.i_sys_clk(clk), .i_rdata(rdata),
		.o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	task automatic chk(string n, logic [31:0] g, logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic rc(logic [7:0] a, logic [31:0] e);
		logic [31:0] v;
		u_phcu_host_model.rd(a, v);
		chk($sformatf("reg %h", a), v, e);
	endtask : rc
	task automatic w(logic [7:0] a, logic [31:0] v);
		u_phcu_host_model.wr(a, v);
	endtask : w
	task automatic hit(logic [31:0] p, logic m, logic em, logic er);
		@(posedge clk);
		probe <= p;
		men <= m;
		repeat (2) @(posedge clk);
		#1 chk("mem_hit", mh, em);
		chk("rom_hit", rh, er);
	endtask : hit
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rc(8'h14, 32'h0);
		rc(8'h2c, 32'h0);
		rc(8'h30, 32'h0);
		rc(8'h34, 32'hc0);
		rc(8'h3c, 32'h100);
		rc(8'h40, 32'h0);
		rc(8'h50, 32'h0);
		@(posedge clk);
		ev <= 1'b1;
		@(posedge clk);
		ev <= 1'b0;
		eid <= 32'h11111111;
		eh <= 16'h0;
		// A later strobe must not reload the identity.
		@(posedge clk);
		ev <= 1'b1;
		@(posedge clk);
		ev <= 1'b0;
		#1 chk("loaded", ld, 1'b1);
		w(8'h2c, 32'h0);
		rc(8'h2c, 32'h5a5a3c3c);
		rc(8'h3c, 32'h12340100);
		w(8'h14, '1);
		rc(8'h14, 32'hffffff80);
		w(8'h30, 32'hfffe0000);
		w(8'h30, '1);
		rc(8'h30, 32'hfffe0001);
		w(8'h3c, '1);
		rc(8'h3c, 32'h123401ff);
		chk("int_line", il, 8'hff);
		w(8'h40, '1);
		rc(8'h40, 32'hff00);
		w(8'h34, '1);
		rc(8'h34, 32'hc0);
		w(8'h14, 32'h12345680);
		w(8'h30, 32'habce0001);
		hit(32'h123456a5, 1'b1, 1'b1, 1'b0);
		hit(32'habcf1234, 1'b1, 1'b0, 1'b1);
		hit(32'habcf1234, 1'b0, 1'b0, 1'b0);
		w(8'h30, 32'habce0000);
		hit(32'habcf1234, 1'b1, 1'b0, 1'b0);
		// Writes during soft reset: scratch is taken, the base is dropped.
		@(posedge clk);
		sr <= 1'b1;
		w(8'h40, 32'h0000ab00);
		w(8'h14, '1);
		sr <= 1'b0;
		rc(8'h14, 32'h0);
		rc(8'h3c, 32'h12340100);
		rc(8'h40, 32'hab00);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rc(8'h40, 32'h0);
		rc(8'h2c, 32'h0);
		stop_test();
	end
endmodule : tb_phcu_config_upper
